/* File: dv/bus_host_model.sv */
/*
 * Bus host controller model: frames block writes and block reads
 * one byte per cycle on the register bank's byte port.
 * Assumes the bench calls its tasks and that all moves land on
 * the falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module bus_host_model
(
  input  wire logic       clk_i,
  output logic            start_o,
  output logic            stop_o,
  output logic            wr_valid_o,
  output logic [7:0]      wr_byte_o,
  output logic            rd_req_o
);
  initial
  begin
    {start_o, stop_o, wr_valid_o, rd_req_o} = 4'h0;
    wr_byte_o = 8'h00;
  end

  task automatic put(input logic [3:0] ctl, input logic [7:0] b);
    @(negedge clk_i);
    {start_o, stop_o, wr_valid_o, rd_req_o} = ctl;
    // Released data line flips, so a stale byte never looks valid
    wr_byte_o = ctl[1] ? b : ~wr_byte_o;
  endtask

  // Start, command, count, data low byte first, stop
  task automatic write_frame(input logic [7:0] cmd, input logic [7:0] cnt,
                             input logic [39:0] data, input int n);
    put(4'h8, 8'h00);
    put(4'h2, cmd);
    put(4'h2, cnt);
    for (int i = 0; i < n; i++)
    begin
      put(4'h2, data[8*i +: 8]);
    end
    put(4'h4, 8'h00);
    put(4'h0, 8'h00);
  endtask

  task automatic read_frame(input logic [7:0] cmd, input int n);
    put(4'h8, 8'h00);
    put(4'h2, cmd);
    repeat (n) put(4'h1, 8'h00);
    put(4'h4, 8'h00);
    put(4'h0, 8'h00);
  endtask
endmodule
`default_nettype wire

/* File: dv/loop_comp_and_bias_cfg_regs_test.sv */
/*
 * Self-checking bench for the compensation and bias command bank.
 * Assumes the bus host model frames all transfers and that read
 * bytes answer one cycle after each request.
 */
`timescale 1ns/1ps
`default_nettype none
`include "comp_bias_regs.svh"
module loop_comp_and_bias_cfg_regs_test
  import comp_bias_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        clk_en_i = 1'b1;
  logic        conv_enable_i = 1'b0;
  logic        nvm_restore_i = 1'b0;
  logic        power_cycle_i = 1'b0;
  logic        boot_load_i = 1'b0;
  logic [39:0] boot_comp_word_i = 40'h0;
  logic [7:0]  boot_bias_cfg_i = 8'h00;
  logic        xfer_start_i, xfer_stop_i, wr_byte_valid_i, rd_byte_req_i;
  logic [7:0]  wr_byte_i, rd_byte_o;
  logic        rd_byte_valid_o, cmd_error_o, comp_pending_o, cur_integ_cap_multiplier_o;
  logic [39:0] stored_comp_word_o, applied_comp_word_o, w, old;
  logic [3:0]  cur_integ_cap_code_o, volt_integ_cap_code_o, bias_voltage_select_o, sel;
  logic [4:0]  cur_filter_cap_code_o, volt_filter_cap_code_o;
  logic [5:0]  cur_gain_resistor_code_o, volt_gain_resistor_code_o;
  logic [1:0]  volt_transconductance_code_o, cur_transconductance_code_o;
  logic [7:0]  exp_q[$];
  int          errors = 0;
  int          compares = 0;

  always #12.5 clk_i = ~clk_i;

  bus_host_model host_u (.clk_i(clk_i), .start_o(xfer_start_i), .stop_o(xfer_stop_i),
    .wr_valid_o(wr_byte_valid_i), .wr_byte_o(wr_byte_i), .rd_req_o(rd_byte_req_i));

  loop_comp_and_bias_cfg_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
    .xfer_start_i(xfer_start_i), .xfer_stop_i(xfer_stop_i), .wr_byte_valid_i(wr_byte_valid_i),
    .wr_byte_i(wr_byte_i), .rd_byte_req_i(rd_byte_req_i), .conv_enable_i(conv_enable_i),
    .nvm_restore_i(nvm_restore_i), .power_cycle_i(power_cycle_i), .boot_load_i(boot_load_i),
    .boot_comp_word_i(boot_comp_word_i), .boot_bias_cfg_i(boot_bias_cfg_i),
    .rd_byte_o(rd_byte_o), .rd_byte_valid_o(rd_byte_valid_o), .cmd_error_o(cmd_error_o),
    .stored_comp_word_o(stored_comp_word_o), .applied_comp_word_o(applied_comp_word_o),
    .cur_integ_cap_code_o(cur_integ_cap_code_o), .cur_filter_cap_code_o(cur_filter_cap_code_o),
    .cur_integ_cap_multiplier_o(cur_integ_cap_multiplier_o),
    .cur_gain_resistor_code_o(cur_gain_resistor_code_o), .volt_integ_cap_code_o(volt_integ_cap_code_o),
    .volt_filter_cap_code_o(volt_filter_cap_code_o), .volt_gain_resistor_code_o(volt_gain_resistor_code_o),
    .volt_transconductance_code_o(volt_transconductance_code_o),
    .cur_transconductance_code_o(cur_transconductance_code_o),
    .bias_voltage_select_o(bias_voltage_select_o), .comp_pending_o(comp_pending_o));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Oldest noted read byte against each answered byte
  always @(negedge clk_i)
  begin
    if (rd_byte_valid_o === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("unrequested read", 40'h0, 40'h1);
      else
        chk("read byte", {32'h0, exp_q.pop_front()}, {32'h0, rd_byte_o});
    end
  end

  task automatic read_expect(input logic [7:0] cmd, input logic [39:0] v, input int n);
    exp_q.push_back(8'(n));
    for (int i = 0; i < n; i++)
      exp_q.push_back(v[8*i +: 8]);
    host_u.read_frame(cmd, n + 1);
    for (int t = 0; t < 8 && exp_q.size() > 0; t++)
      @(negedge clk_i);
    if (exp_q.size() != 0)
    begin
      chk("missing read bytes", 40'h0, 40'(exp_q.size()));
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] cnt, input logic [39:0] v, input int n);
    host_u.write_frame(cmd, cnt, v, n);
    @(negedge clk_i);
  endtask

  task automatic strobe(input logic [2:0] k);
    @(negedge clk_i);
    {nvm_restore_i, power_cycle_i, boot_load_i} = k;
    @(negedge clk_i);
    {nvm_restore_i, power_cycle_i, boot_load_i} = 3'b000;
    @(negedge clk_i);
  endtask

  task automatic chk_fields(input logic [39:0] v);
    chk("applied word", v, applied_comp_word_o);
    chk("cur integ cap", {v[25:24], v[39:38]}, cur_integ_cap_code_o);
    chk("cur filter cap", v[37:33], cur_filter_cap_code_o);
    chk("cur multiplier", v[32], cur_integ_cap_multiplier_o);
    chk("cur gain res", v[31:26], cur_gain_resistor_code_o);
    chk("volt integ cap", {v[9:8], v[23:22]}, volt_integ_cap_code_o);
    chk("volt filter cap", v[21:17], volt_filter_cap_code_o);
    chk("volt gain res", v[15:10], volt_gain_resistor_code_o);
    chk("volt gm", v[5:4], volt_transconductance_code_o);
    chk("cur gm", v[1:0], cur_transconductance_code_o);
  endtask

  // Reserved compensation bits always sent as zero
  function automatic logic [39:0] rnd_word();
    return {8'($urandom), $urandom} & `COMP_WRITABLE_MASK;
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(71));
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    chk("reset bias select", `BIAS_RESET_SEL, bias_voltage_select_o);
    chk_fields(40'h0);
    read_expect(`CMD_BIAS_CFG, 40'h80, 1);
    read_expect(`CMD_COMP_WORD, 40'h0, 5);
    w = rnd_word();
    boot_comp_word_i = w;
    boot_bias_cfg_i = 8'h5A;
    strobe(3'b001);
    chk("boot stored word", w, stored_comp_word_o);
    chk_fields(w);
    read_expect(`CMD_BIAS_CFG, 40'h50, 1);
    repeat (4)
    begin
      w = rnd_word();
      wr(`CMD_COMP_WORD, 8'h05, w, 5);
      chk_fields(w);
      chk("pending", 1'b0, comp_pending_o);
      read_expect(`CMD_COMP_WORD, w, 5);
    end
    conv_enable_i = 1'b1;
    // Store, then restore or supply cycle
    for (int k = 0; k < 2; k++)
    begin
      old = w;
      w = rnd_word();
      wr(`CMD_COMP_WORD, 8'h05, w, 5);
      chk("stored word", w, stored_comp_word_o);
      chk_fields(old);
      chk("pending", 1'b1, comp_pending_o);
      strobe(k == 0 ? 3'b100 : 3'b010);
      chk_fields(w);
      chk("pending", 1'b0, comp_pending_o);
    end
    // Every code; 0h..2h and Bh..Fh only because this bench has no supply to protect
    sel = 4'h5;
    for (int c = 0; c < 16; c++)
    begin
      wr(`CMD_BIAS_CFG, 8'h01, {32'h0, c[3:0], 4'($urandom)}, 1);
      if (c >= 3 && c <= 10)
        sel = c[3:0];
      chk("bias select", sel, bias_voltage_select_o);
      read_expect(`CMD_BIAS_CFG, {32'h0, c[3:0], 4'h0}, 1);
    end
    wr(`CMD_COMP_WORD, 8'h04, rnd_word(), 4);
    chk("short count", w, stored_comp_word_o);
    wr(`CMD_COMP_WORD, 8'h05, rnd_word(), 4);
    chk("short data", w, stored_comp_word_o);
    wr(8'hC0, 8'h01, 40'h0F, 1);
    chk("command error", 1'b1, cmd_error_o);
    clk_en_i = 1'b0;
    wr(`CMD_BIAS_CFG, 8'h01, 40'h40, 1);
    clk_en_i = 1'b1;
    chk("frozen bias", sel, bias_voltage_select_o);
    read_expect(`CMD_BIAS_CFG, 40'hF0, 1);
    chk("command error cleared", 1'b0, cmd_error_o);
    test_done();
  end
endmodule
`default_nettype wire

/* File: src/bias_code_check.sv */
/*
 * Validates a bias regulator voltage code.
 * Assumes a purely combinational use by the register bank.
 */
`timescale 1ns/1ps
`default_nettype none
`include "comp_bias_regs.svh"
module bias_code_check
  import comp_bias_pkg::*;
(
  input  wire logic [3:0] code_i,
  output logic            valid_o
);
  // Codes outside 3h..Ah have no regulator setting
  assign valid_o = (code_i >= `BIAS_CODE_MIN) && (code_i <= `BIAS_CODE_MAX);
endmodule
`default_nettype wire

/* File: src/comp_bias_pkg.sv */
/*
 * Types shared by the compensation and bias configuration block.
 * Assumes the register header supplies all numeric constants.
 */
package comp_bias_pkg;
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_CMD   = 2'b01,
    ST_DATA  = 2'b11,
    ST_DROP  = 2'b10
  } xfer_state_type;
endpackage

/* File: src/comp_bias_regs.svh */
/*
 * Register codes, field positions and timing constants of the
 * compensation and bias configuration commands.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef COMP_BIAS_REGS_SVH
`define COMP_BIAS_REGS_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_COMP_WORD        8'hB1
`define CMD_BIAS_CFG         8'hB5
`define COMP_BYTES           3'h5
`define BIAS_BYTES           3'h1

// ----------------------------------------------------------------
// Compensation word field positions
// ----------------------------------------------------------------
`define CZI_LO_HI            39
`define CZI_LO_LO            38
`define CPI_HI               37
`define CPI_LO               33
`define CZI_MUL_BIT          32
`define RVI_HI               31
`define RVI_LO               26
`define CZI_HI_HI            25
`define CZI_HI_LO            24
`define CZV_LO_HI            23
`define CZV_LO_LO            22
`define CPV_HI               21
`define CPV_LO               17
`define RVV_HI               15
`define RVV_LO               10
`define CZV_HI_HI            9
`define CZV_HI_LO            8
`define GMV_HI               5
`define GMV_LO               4
`define GMI_HI               1
`define GMI_LO               0
`define COMP_WRITABLE_MASK   40'hFFFFFEFF33

// ----------------------------------------------------------------
// Bias configuration fields and codes
// ----------------------------------------------------------------
`define BIAS_SEL_HI          7
`define BIAS_SEL_LO          4
`define BIAS_RO_MASK         8'hF0
`define BIAS_CODE_MIN        4'h3
`define BIAS_CODE_MAX        4'hA
`define BIAS_RESET_SEL       4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS        25
`define BIAS_MAX_ACTION_NS   1000000
`define BIAS_MAX_ACTION_CYC  (`BIAS_MAX_ACTION_NS / `CLK_PERIOD_NS)

`endif

/* File: src/comp_field_decode.sv */
/*
 * Splits the applied compensation word into loop-hardware codes.
 * Assumes the word presented is the one the loop should use.
 */
`timescale 1ns/1ps
`default_nettype none
`include "comp_bias_regs.svh"
module comp_field_decode
  import comp_bias_pkg::*;
(
  input  wire logic [39:0] word_i,
  output logic      [3:0]  cur_integ_cap_code_o,
  output logic      [4:0]  cur_filter_cap_code_o,
  output logic             cur_integ_cap_multiplier_o,
  output logic      [5:0]  cur_gain_resistor_code_o,
  output logic      [3:0]  volt_integ_cap_code_o,
  output logic      [4:0]  volt_filter_cap_code_o,
  output logic      [5:0]  volt_gain_resistor_code_o,
  output logic      [1:0]  volt_transconductance_code_o,
  output logic      [1:0]  cur_transconductance_code_o
);
  // Split codes: high pair sits lower in the word
  assign cur_integ_cap_code_o = {word_i[`CZI_HI_HI:`CZI_HI_LO], word_i[`CZI_LO_HI:`CZI_LO_LO]};
  assign cur_filter_cap_code_o = word_i[`CPI_HI:`CPI_LO];
  assign cur_integ_cap_multiplier_o = word_i[`CZI_MUL_BIT];
  assign cur_gain_resistor_code_o = word_i[`RVI_HI:`RVI_LO];
  assign volt_integ_cap_code_o = {word_i[`CZV_HI_HI:`CZV_HI_LO], word_i[`CZV_LO_HI:`CZV_LO_LO]};
  assign volt_filter_cap_code_o = word_i[`CPV_HI:`CPV_LO];
  assign volt_gain_resistor_code_o = word_i[`RVV_HI:`RVV_LO];
  assign volt_transconductance_code_o = word_i[`GMV_HI:`GMV_LO];
  assign cur_transconductance_code_o = word_i[`GMI_HI:`GMI_LO];
endmodule
`default_nettype wire

/* File: src/loop_comp_and_bias_cfg_regs.sv */
/*
 * Compensation word and bias configuration commands behind a
 * byte-wide block read/write port from the bus host controller.
 * Assumes the controller frames each block transfer: start, command
 * byte, byte count, data bytes low first, stop. Read bytes are
 * requested one at a time after the command byte.
 */
`timescale 1ns/1ps
`default_nettype none
`include "comp_bias_regs.svh"
module loop_comp_and_bias_cfg_regs
  import comp_bias_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        xfer_start_i,
  input  wire logic        xfer_stop_i,
  input  wire logic        wr_byte_valid_i,
  input  wire logic [7:0]  wr_byte_i,
  input  wire logic        rd_byte_req_i,
  input  wire logic        conv_enable_i,
  input  wire logic        nvm_restore_i,
  input  wire logic        power_cycle_i,
  input  wire logic        boot_load_i,
  input  wire logic [39:0] boot_comp_word_i,
  input  wire logic [7:0]  boot_bias_cfg_i,
  output logic [7:0]       rd_byte_o,
  output logic             rd_byte_valid_o,
  output logic             cmd_error_o,
  output logic [39:0]      stored_comp_word_o,
  output logic [39:0]      applied_comp_word_o,
  output logic [3:0]       cur_integ_cap_code_o,
  output logic [4:0]       cur_filter_cap_code_o,
  output logic             cur_integ_cap_multiplier_o,
  output logic [5:0]       cur_gain_resistor_code_o,
  output logic [3:0]       volt_integ_cap_code_o,
  output logic [4:0]       volt_filter_cap_code_o,
  output logic [5:0]       volt_gain_resistor_code_o,
  output logic [1:0]       volt_transconductance_code_o,
  output logic [1:0]       cur_transconductance_code_o,
  output logic [3:0]       bias_voltage_select_o,
  output logic             comp_pending_o
);
  // ----------------------------------------------------------------
  // Transfer tracking
  // ----------------------------------------------------------------
  xfer_state_type state_q;
  logic [7:0]     cmd_q;
  logic [2:0]     idx_q;
  logic           count_seen_q;
  logic [2:0]     count_q;
  logic [39:0]    shadow_q;
  logic [7:0]     bias_shadow_q;
  logic [39:0]    stored_q;
  logic [7:0]     bias_q;
  logic [39:0]    applied_q;
  logic [3:0]     bias_applied_q;
  logic           pending_q;
  logic           bias_valid;
  logic [39:0]    applied_d;

  function automatic logic [2:0] cmd_len(input logic [7:0] cmd);
    cmd_len = (cmd == `CMD_COMP_WORD) ? `COMP_BYTES :
              (cmd == `CMD_BIAS_CFG)  ? `BIAS_BYTES : 3'h0;
  endfunction

  logic comp_commit;
  logic bias_commit;
  // Commit only a complete block write with matching count
  assign comp_commit = xfer_stop_i && (state_q == ST_DATA) && count_seen_q &&
                       (cmd_q == `CMD_COMP_WORD) && (count_q == `COMP_BYTES) && (idx_q == `COMP_BYTES);
  assign bias_commit = xfer_stop_i && (state_q == ST_DATA) && count_seen_q &&
                       (cmd_q == `CMD_BIAS_CFG) && (count_q == `BIAS_BYTES) && (idx_q == `BIAS_BYTES);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q      <= ST_IDLE;
      cmd_q        <= 8'h00;
      idx_q        <= 3'h0;
      count_seen_q <= 1'b0;
      count_q      <= 3'h0;
    end
    else if (clk_en_i)
    begin
      if (xfer_start_i)
      begin
        state_q      <= ST_CMD;
        idx_q        <= 3'h0;
        count_seen_q <= 1'b0;
      end
      else if (xfer_stop_i)
      begin
        state_q <= ST_IDLE;
      end
      else if (wr_byte_valid_i)
      begin
        unique case (state_q)
          ST_IDLE: state_q <= ST_IDLE;
          ST_CMD:
          begin
            cmd_q   <= wr_byte_i;
            state_q <= (cmd_len(wr_byte_i) != 3'h0) ? ST_DATA : ST_DROP;
          end
          ST_DATA:
          begin
            if (!count_seen_q)
            begin
              count_seen_q <= 1'b1;
              count_q      <= (wr_byte_i == {5'h00, cmd_len(cmd_q)}) ? cmd_len(cmd_q) : 3'h0;
              if (wr_byte_i != {5'h00, cmd_len(cmd_q)})
                state_q <= ST_DROP;
            end
            else if (idx_q < cmd_len(cmd_q))
              idx_q <= idx_q + 3'h1;
            else
              state_q <= ST_DROP;
          end
          ST_DROP: state_q <= ST_DROP;
        endcase
      end
      else if (rd_byte_req_i && (state_q == ST_DATA))
      begin
        if (idx_q <= cmd_len(cmd_q))
          idx_q <= idx_q + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shadow capture of incoming data bytes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shadow_q      <= 40'h00_0000_0000;
      bias_shadow_q <= 8'h00;
    end
    else if (clk_en_i && wr_byte_valid_i && (state_q == ST_DATA) && count_seen_q && (idx_q < cmd_len(cmd_q)))
    begin
      if (cmd_q == `CMD_COMP_WORD)
        shadow_q[idx_q*8 +: 8] <= wr_byte_i;
      else
        bias_shadow_q <= wr_byte_i;
    end
  end

  // ----------------------------------------------------------------
  // Stored command values
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stored_q <= 40'h00_0000_0000;
    else if (clk_en_i)
    begin
      if (boot_load_i)
        stored_q <= boot_comp_word_i;
      else if (comp_commit)
        stored_q <= shadow_q;
    end
  end

  bias_code_check u_bias_check
  (
    .code_i  (bias_shadow_q[`BIAS_SEL_HI:`BIAS_SEL_LO]),
    .valid_o (bias_valid)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bias_q         <= {`BIAS_RESET_SEL, 4'h0};
      bias_applied_q <= `BIAS_RESET_SEL;
    end
    else if (clk_en_i)
    begin
      if (boot_load_i)
      begin
        bias_q         <= boot_bias_cfg_i & `BIAS_RO_MASK;
        bias_applied_q <= boot_bias_cfg_i[`BIAS_SEL_HI:`BIAS_SEL_LO];
      end
      else if (bias_commit)
      begin
        bias_q <= bias_shadow_q & `BIAS_RO_MASK;
        // One cycle after stop, far inside the 1 ms action bound
        if (bias_valid)
          bias_applied_q <= bias_shadow_q[`BIAS_SEL_HI:`BIAS_SEL_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Hardware update gate
  // ----------------------------------------------------------------
  always_comb
  begin
    applied_d = applied_q;
    if (boot_load_i || nvm_restore_i || power_cycle_i)
      applied_d = boot_load_i ? boot_comp_word_i : stored_q;
    else if (comp_commit && !conv_enable_i)
      applied_d = shadow_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      applied_q <= 40'h00_0000_0000;
      pending_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      applied_q <= applied_d;
      if (boot_load_i || nvm_restore_i || power_cycle_i)
        pending_q <= 1'b0;
      else if (comp_commit)
        pending_q <= conv_enable_i;
    end
  end

  // ----------------------------------------------------------------
  // Read path and error flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_byte_o       <= 8'h00;
      rd_byte_valid_o <= 1'b0;
      cmd_error_o     <= 1'b0;
    end
    else if (clk_en_i)
    begin
      rd_byte_valid_o <= 1'b0;
      if (xfer_start_i)
        cmd_error_o <= 1'b0;
      else if (wr_byte_valid_i && (state_q == ST_CMD) && (cmd_len(wr_byte_i) == 3'h0))
        cmd_error_o <= 1'b1;
      else if (xfer_stop_i && (state_q == ST_DATA) && count_seen_q && (idx_q != cmd_len(cmd_q)))
        cmd_error_o <= 1'b1;
      if (rd_byte_req_i && (state_q == ST_DATA) && !wr_byte_valid_i && !xfer_start_i && !xfer_stop_i)
      begin
        rd_byte_valid_o <= 1'b1;
        // First read byte is the block count
        if (idx_q == 3'h0)
          rd_byte_o <= {5'h00, cmd_len(cmd_q)};
        else if (idx_q > cmd_len(cmd_q))
          rd_byte_o <= 8'h00;
        else if (cmd_q == `CMD_COMP_WORD)
          rd_byte_o <= stored_q[(idx_q - 3'h1)*8 +: 8];
        else
          rd_byte_o <= bias_q;
      end
    end
  end

  comp_field_decode u_decode
  (
    .word_i                       (applied_q),
    .cur_integ_cap_code_o         (cur_integ_cap_code_o),
    .cur_filter_cap_code_o        (cur_filter_cap_code_o),
    .cur_integ_cap_multiplier_o   (cur_integ_cap_multiplier_o),
    .cur_gain_resistor_code_o     (cur_gain_resistor_code_o),
    .volt_integ_cap_code_o        (volt_integ_cap_code_o),
    .volt_filter_cap_code_o       (volt_filter_cap_code_o),
    .volt_gain_resistor_code_o    (volt_gain_resistor_code_o),
    .volt_transconductance_code_o (volt_transconductance_code_o),
    .cur_transconductance_code_o  (cur_transconductance_code_o)
  );

  assign stored_comp_word_o    = stored_q;
  assign applied_comp_word_o   = applied_q;
  assign bias_voltage_select_o = bias_applied_q;
  assign comp_pending_o        = pending_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_enabled_hold;
    @(posedge clk_i) disable iff (rst_i)
    (clk_en_i && comp_commit && conv_enable_i && !boot_load_i && !nvm_restore_i && !power_cycle_i)
      |=> (applied_q == $past(applied_q)) && (stored_q == $past(shadow_q)) && pending_q;
  endproperty
  a_enabled_hold: assert property (p_enabled_hold) else $error("enabled write reached loop");

  property p_disabled_apply;
    @(posedge clk_i) disable iff (rst_i)
    (clk_en_i && comp_commit && !conv_enable_i && !boot_load_i && !nvm_restore_i && !power_cycle_i)
      |=> (applied_q == $past(shadow_q));
  endproperty
  a_disabled_apply: assert property (p_disabled_apply) else $error("disabled write not applied");

  property p_restore_copy;
    @(posedge clk_i) disable iff (rst_i)
    (clk_en_i && (nvm_restore_i || power_cycle_i) && !boot_load_i) |=> (applied_q == $past(stored_q)) && !pending_q;
  endproperty
  a_restore_copy: assert property (p_restore_copy) else $error("restore did not copy");

  property p_boot_load;
    @(posedge clk_i) disable iff (rst_i)
    (clk_en_i && boot_load_i) |=> (stored_q == $past(boot_comp_word_i)) && (applied_q == stored_q);
  endproperty
  a_boot_load: assert property (p_boot_load) else $error("power-up value not loaded");

  property p_no_spurious;
    @(posedge clk_i) disable iff (rst_i)
    (applied_q != $past(applied_q)) |->
      $past(clk_en_i && (boot_load_i || nvm_restore_i || power_cycle_i || (comp_commit && !conv_enable_i)));
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("loop word changed unprompted");

  property p_bias_ro;
    @(posedge clk_i) disable iff (rst_i)
    (bias_q[3:0] == 4'h0);
  endproperty
  a_bias_ro: assert property (p_bias_ro) else $error("bias low nibble not zero");

  property p_bias_invalid_keep;
    @(posedge clk_i) disable iff (rst_i)
    (clk_en_i && bias_commit && !bias_valid && !boot_load_i) |=> $stable(bias_applied_q);
  endproperty
  a_bias_invalid_keep: assert property (p_bias_invalid_keep) else $error("invalid bias applied");

  property p_bias_apply;
    @(posedge clk_i) disable iff (rst_i)
    (clk_en_i && bias_commit && bias_valid && !boot_load_i)
      |=> (bias_applied_q == $past(bias_shadow_q[`BIAS_SEL_HI:`BIAS_SEL_LO])) &&
          (bias_applied_q >= `BIAS_CODE_MIN) && (bias_applied_q <= `BIAS_CODE_MAX);
  endproperty
  a_bias_apply: assert property (p_bias_apply) else $error("bias not applied on the fly");

  property p_decode;
    @(posedge clk_i) disable iff (rst_i)
    (cur_integ_cap_code_o == {applied_q[25:24], applied_q[39:38]}) &&
    (volt_integ_cap_code_o == {applied_q[9:8], applied_q[23:22]}) && (cur_transconductance_code_o == applied_q[1:0]);
  endproperty
  a_decode: assert property (p_decode) else $error("split field decode wrong");

  property p_comp_len;
    @(posedge clk_i) disable iff (rst_i)
    comp_commit |-> (count_q == `COMP_BYTES);
  endproperty
  a_comp_len: assert property (p_comp_len) else $error("compensation block length wrong");
endmodule
`default_nettype wire
